/* File: verilog/pgd_pkg.sv */
/*
  package for the line driver gain, clock delay and discharge counter registers.
  assumes a 16-bit register space reached over a plain strobe port.
*/
package pgd_pkg;
  localparam int PGD_ADDR_W = 16;
  localparam int PGD_DATA_W = 16;
  localparam int PGD_CNT_W = 6;
  // register offsets
  localparam logic [15:0] PGD_OFS_GAIN = 16'h0401;
  localparam logic [15:0] PGD_OFS_DELAY = 16'h0446;
  localparam logic [15:0] PGD_OFS_ESD = 16'h0448;
  // field positions
  localparam int PGD_GAIN_LSB = 0;
  localparam int PGD_RSVD_LSB = 4;
  localparam int PGD_RX_DLY_LSB = 0;
  localparam int PGD_TX_DLY_LSB = 4;
  localparam int PGD_LINE_CNT_LSB = 0;
  localparam int PGD_MAC_CNT_LSB = 8;
  // reset values
  localparam logic [3:0] PGD_GAIN_RST = 4'ha;
  localparam logic [11:0] PGD_RSVD_RST = 12'h000;
  localparam logic [3:0] PGD_TX_DLY_RST = 4'h7;
  localparam logic [3:0] PGD_RX_DLY_RST = 4'h7;
  localparam logic [3:0] PGD_GAIN_NOMINAL = 4'h8;
  // delay step in ps; delay is (code + 1) steps
  localparam int PGD_DLY_STEP_PS = 250;
  localparam logic [5:0] PGD_CNT_MAX = 6'h3f;
  localparam logic [5:0] PGD_CNT_ZERO = 6'h00;
endpackage

/* File: verilog/pgd_cnt_if.sv */
/*
  interface carrying the discharge event strobes and the counts between
  the register bank and its counter module. assumes one clock.
*/
`timescale 1ns/1ns
interface pgd_cnt_if;
  logic mac_event;
  logic line_event;
  logic [5:0] mac_count;
  logic [5:0] line_count;
  modport bank (output mac_event, output line_event, input mac_count, input line_count);
  modport counter (input mac_event, input line_event, output mac_count, output line_count);
endinterface

/* File: verilog/pgd_esd_counter.sv */
/*
  two saturating discharge event counters cleared only at power-up.
  assumes power-on reset is separate from the hardware reset.
*/
`timescale 1ns/1ns
module pgd_esd_counter
  import pgd_pkg::*;
(
  // clock and power-on reset
  input wire logic clk_in,
  input wire logic por_n_in,
  // events and counts
  pgd_cnt_if.counter cnt
);
  typedef struct packed {
    logic [5:0] mac;
    logic [5:0] line;
  } pgd_cnt_s;
  pgd_cnt_s st;
  pgd_cnt_s next_st;
  always_comb begin
    next_st = st;
    // counted every cycle the event is high: no dead time
    if (cnt.mac_event && st.mac != PGD_CNT_MAX) begin
      next_st.mac = st.mac + 6'h01;
    end
    if (cnt.line_event && st.line != PGD_CNT_MAX) begin
      next_st.line = st.line + 6'h01;
    end
  end
  // hardware reset deliberately does not reach these flops
  always_ff @(posedge clk_in) begin
    if (!por_n_in) begin
      st <= '{mac: PGD_CNT_ZERO, line: PGD_CNT_ZERO};
    end else begin
      st <= next_st;
    end
  end
  assign cnt.mac_count = st.mac;
  assign cnt.line_count = st.line;
  ////////////////////////////////////////////////////////////////////////
  mac_count_up_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    cnt.mac_event && st.mac < PGD_CNT_MAX |=> st.mac == $past(st.mac) + 6'h01)
    else $error("mac counter missed event");
  line_count_up_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    cnt.line_event && st.line < PGD_CNT_MAX |=> st.line == $past(st.line) + 6'h01)
    else $error("line counter missed event");
  back_to_back_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    cnt.mac_event[*2] ##0 (st.mac < 6'h3e) |=> st.mac == $past(st.mac, 2) + 6'h02)
    else $error("dead time seen on mac counter");
  saturate_hold_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    st.line == PGD_CNT_MAX |=> st.line == PGD_CNT_MAX)
    else $error("line counter wrapped");
  mac_saturate_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    st.mac == PGD_CNT_MAX |=> st.mac == PGD_CNT_MAX)
    else $error("mac counter wrapped");
  idle_stable_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    !cnt.mac_event |=> $stable(st.mac))
    else $error("mac counter moved without event");
  line_idle_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    !cnt.line_event |=> $stable(st.line))
    else $error("line counter moved without event");
  cov_saturate: cover property (@(posedge clk_in) st.mac == PGD_CNT_MAX);
  cov_burst: cover property (@(posedge clk_in) cnt.line_event[*3]);
endmodule

/* File: verilog/pgd_regs.sv */
/*
  register bank: line driver fine gain, interface clock delay codes and
  discharge event counts. assumes a plain strobe bus, read data one cycle
  after the read strobe; por_n_in comes from a power-on detector.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module pgd_regs
  import pgd_pkg::*;
(
  // clock and resets
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  // register port
  input wire logic [PGD_ADDR_W-1:0] addr_in,
  input wire logic [PGD_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [PGD_DATA_W-1:0] rdata_out,
  // discharge detectors, one cycle high per activation
  input wire logic mac_esd_in,
  input wire logic line_esd_in,
  // settings to the analog blocks
  output logic [3:0] line_driver_fine_gain_out,
  output logic [3:0] tx_clk_delay_out,
  output logic [3:0] rx_clk_delay_out
);
  typedef struct packed {
    logic [3:0] gain;
    logic [11:0] gain_rsvd;
    logic [3:0] tx_dly;
    logic [3:0] rx_dly;
    logic [15:0] rdata;
  } pgd_regs_s;
  pgd_regs_s st;
  pgd_regs_s next_st;
  pgd_cnt_if cnt_bus ();
  ////////////////////////////////////////////////////////////////////////
  assign cnt_bus.mac_event = mac_esd_in;
  assign cnt_bus.line_event = line_esd_in;
  pgd_esd_counter u_cnt (
    .clk_in(clk_in),
    .por_n_in(por_n_in),
    .cnt(cnt_bus.counter)
  );
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (wr_in) begin
      case (addr_in)
        PGD_OFS_GAIN: begin
          next_st.gain = wdata_in[PGD_GAIN_LSB +: 4];
          next_st.gain_rsvd = wdata_in[PGD_RSVD_LSB +: 12];
        end
        PGD_OFS_DELAY: begin
          next_st.tx_dly = wdata_in[PGD_TX_DLY_LSB +: 4];
          next_st.rx_dly = wdata_in[PGD_RX_DLY_LSB +: 4];
        end
        default: begin
          next_st.gain = st.gain;
        end
      endcase
    end
    // unmapped reads return zero; rdata holds only for the cycle after
    next_st.rdata = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        PGD_OFS_GAIN: next_st.rdata = {st.gain_rsvd, st.gain};
        PGD_OFS_DELAY: next_st.rdata = {8'h00, st.tx_dly, st.rx_dly};
        PGD_OFS_ESD: next_st.rdata = {2'h0, cnt_bus.mac_count, 2'h0, cnt_bus.line_count};
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st.gain <= PGD_GAIN_RST;
      st.gain_rsvd <= PGD_RSVD_RST;
      st.tx_dly <= PGD_TX_DLY_RST;
      st.rx_dly <= PGD_RX_DLY_RST;
      st.rdata <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end
  assign rdata_out = st.rdata;
  assign line_driver_fine_gain_out = st.gain;
  assign tx_clk_delay_out = st.tx_dly;
  assign rx_clk_delay_out = st.rx_dly;
  ////////////////////////////////////////////////////////////////////////
  gain_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == PGD_OFS_GAIN |=> line_driver_fine_gain_out == $past(wdata_in[3:0]))
    else $error("gain write lost");
  gain_reset_a: assert property (@(posedge clk_in)
    !rst_n_in |=> line_driver_fine_gain_out == PGD_GAIN_RST)
    else $error("gain reset value wrong");
  gain_rsvd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == PGD_OFS_GAIN |=> st.gain_rsvd == $past(wdata_in[15:4]))
    else $error("gain reserved write lost");
  tx_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == PGD_OFS_DELAY |=> tx_clk_delay_out == $past(wdata_in[7:4]))
    else $error("tx delay write lost");
  rx_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == PGD_OFS_DELAY |=> rx_clk_delay_out == $past(wdata_in[3:0]))
    else $error("rx delay write lost");
  rx_reset_a: assert property (@(posedge clk_in)
    !rst_n_in |=> rx_clk_delay_out == PGD_RX_DLY_RST && tx_clk_delay_out == PGD_TX_DLY_RST)
    else $error("delay reset value wrong");
  delay_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == PGD_OFS_DELAY |=>
      rdata_out[7:0] == $past({tx_clk_delay_out, rx_clk_delay_out}))
    else $error("delay codes read wrong");
  delay_rsvd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == PGD_OFS_DELAY |=> rdata_out[15:8] == 8'h00)
    else $error("delay reserved bits not zero");
  esd_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == PGD_OFS_ESD |=> rdata_out[13:8] == $past(cnt_bus.mac_count)
      && rdata_out[15:14] == 2'h0 && rdata_out[7:6] == 2'h0)
    else $error("discharge count read wrong");
  line_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == PGD_OFS_ESD |=> rdata_out[5:0] == $past(cnt_bus.line_count))
    else $error("line count read wrong");
  survive_reset_a: assert property (@(posedge clk_in) disable iff (!por_n_in)
    !rst_n_in && !mac_esd_in |=> cnt_bus.mac_count == $past(cnt_bus.mac_count))
    else $error("hardware reset touched counter");
  cov_gain_wr: cover property (@(posedge clk_in) wr_in && addr_in == PGD_OFS_GAIN);
  cov_esd_rd: cover property (@(posedge clk_in) rd_in && addr_in == PGD_OFS_ESD);
  cov_rst_cnt: cover property (@(posedge clk_in) !rst_n_in && cnt_bus.mac_count != 6'h00);
endmodule

/* File: verif/pgd_regs_tb.sv */
/*
  self-checking bench for the gain, clock delay and discharge count registers.
  assumes the plain strobe port of pgd_regs, read data one cycle after rd_in.
*/
`timescale 1ns/1ns
module testbench;
  import pgd_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic por_n_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic mac_esd_in = 1'b0;
  logic line_esd_in = 1'b0;
  logic [15:0] rdata_out;
  logic [3:0] gain_out;
  logic [3:0] tx_out;
  logic [3:0] rx_out;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  pgd_regs i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .mac_esd_in(mac_esd_in), .line_esd_in(line_esd_in),
    .line_driver_fine_gain_out(gain_out), .tx_clk_delay_out(tx_out),
    .rx_clk_delay_out(rx_out));
  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // read data is looked at only in the one cycle where it stands
  task automatic rd(input string name, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(name, exp, rdata_out);
  endtask
  task automatic ev(input logic m, input logic l, input int n);
    @(posedge clk_in);
    mac_esd_in <= m;
    line_esd_in <= l;
    repeat (n) @(posedge clk_in);
    mac_esd_in <= 1'b0;
    line_esd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rd("gain", PGD_OFS_GAIN, 16'h000a);
    rd("delay", PGD_OFS_DELAY, 16'h0077);
    rd("counts", PGD_OFS_ESD, 16'h0000);
    chk("gain_out", 16'h000a, {12'h000, gain_out});
    chk("tx_out", 16'h0007, {12'h000, tx_out});
    chk("rx_out", 16'h0007, {12'h000, rx_out});
    $display("test reset_values done");
  endtask
  task automatic t_write_read();
    wr(PGD_OFS_GAIN, 16'hfff5);
    rd("gain rw", PGD_OFS_GAIN, 16'hfff5);
    wr(PGD_OFS_DELAY, 16'hffa3);
    rd("delay rsvd", PGD_OFS_DELAY, 16'h00a3);
    @(posedge clk_in);
    #1;
    chk("rdata idle", 16'h0000, rdata_out);
    chk("gain_out", 16'h0005, {12'h000, gain_out});
    chk("tx_out", 16'h000a, {12'h000, tx_out});
    chk("rx_out", 16'h0003, {12'h000, rx_out});
    wr(PGD_OFS_ESD, 16'hffff);
    rd("counts ro", PGD_OFS_ESD, 16'h0000);
    rd("unmapped", 16'h0447, 16'h0000);
    $display("test write_read done");
  endtask
  // back-to-back events count every cycle, no dead time
  task automatic t_events();
    ev(1'b1, 1'b0, 3);
    ev(1'b0, 1'b1, 2);
    rd("counts", PGD_OFS_ESD, 16'h0302);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd("counts kept", PGD_OFS_ESD, 16'h0302);
    rd("gain reset", PGD_OFS_GAIN, 16'h000a);
    rd("delay reset", PGD_OFS_DELAY, 16'h0077);
    chk("tx_out reset", 16'h0007, {12'h000, tx_out});
    chk("rx_out reset", 16'h0007, {12'h000, rx_out});
    $display("test events done");
  endtask
  // 70 more pulses pass 63, so a wrapping counter would read back 0908
  task automatic t_saturate();
    ev(1'b1, 1'b1, 70);
    rd("counts sat", PGD_OFS_ESD, 16'h3f3f);
    // a power cycle alone must clear both counters
    @(posedge clk_in);
    por_n_in <= 1'b0;
    @(posedge clk_in);
    por_n_in <= 1'b1;
    rd("counts por", PGD_OFS_ESD, 16'h0000);
    $display("test saturate done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    t_reset_values();
    t_write_read();
    t_events();
    t_saturate();
    final_report();
  end
endmodule
